//--- pcfg_map.svh
// Purpose: Register offsets, field masks and reset values for the port configuration block
// Assumes: Offsets are relative to the io_register_block base
// Notes: Address is {port[1:0], register[3:0]} inside the low six bits
`ifndef PCFG_MAP_SVH
`define PCFG_MAP_SVH
`define PCFG_REG_DATA_IN 4'h0
`define PCFG_REG_MODE 4'h1
`define PCFG_REG_DATA_OUT 4'h2
`define PCFG_REG_DIR 4'h3
`define PCFG_REG_DRIVE 4'h4
`define PCFG_REG_IN_CELL 4'h5
`define PCFG_REG_OE_STAT 4'h6
`define PCFG_REG_OUT_CELL 4'h7
`define PCFG_REG_MASK 4'h8
`define PCFG_RESET_VAL 8'h00
`define PCFG_D_USED 8'h06
`define PCFG_AB_OPEN_DRAIN 8'hf0
`define PCFG_AB_SLEW 8'h0f
`define PCFG_C_OPEN_DRAIN 8'hff
`define PCFG_D_SLEW 8'h06
`define PCFG_PERIPH_BIT 7
`endif

//--- pcfg_pkg.sv
// Purpose: Types shared by the port configuration block
// Assumes: Nothing beyond the map header
// Notes: Pad fields are per pin, bit n for pin n
package pcfg_pkg;
    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcfg_bus_type;

    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] fast;
    } pcfg_pad_type;
endpackage : pcfg_pkg

//--- pcfg_port_regs.sv
// Purpose: Configuration and data registers for ports A to D
// Assumes: Host cycles and pins synchronous to CLOCK
// Notes: Read data lags the read by one clock; pad outputs lag direct inputs by one clock and host register writes by two
`timescale 1ns/1ps
`include "pcfg_map.svh"

module pcfg_port_regs #(
    parameter bit AB_ON_B = 1'b0,
    parameter bit BC_ON_C = 1'b1,
    parameter logic [31:0] CELL_PINS = 32'h0000_0000
) (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire pcfg_pkg::pcfg_bus_type HOST,
    output logic [7:0] RDATA,
    input wire logic [31:0] PIN_IN,
    output pcfg_pkg::pcfg_pad_type PAD_A,
    output pcfg_pkg::pcfg_pad_type PAD_B,
    output pcfg_pkg::pcfg_pad_type PAD_C,
    output pcfg_pkg::pcfg_pad_type PAD_D,
    input wire logic [23:0] PLA_OE,
    input wire logic [7:0] CELL_AB_D,
    input wire logic [7:0] CELL_BC_D,
    input wire logic CELL_CE,
    output logic [7:0] CELL_AB_Q,
    output logic [7:0] CELL_BC_Q,
    input wire logic [2:0] IN_CELL_CAPTURE,
    output logic [23:0] IN_CELL_Q,
    input wire logic [7:0] LATCHED_ADDR,
    input wire logic [7:0] MEM_MODE,
    input wire logic PERIPH_SEL_0,
    input wire logic PERIPH_SEL_1,
    input wire logic [7:0] HOST_DATA,
    input wire logic HOST_DATA_WR,
    output logic [7:0] PERIPH_RDATA
);

    logic [7:0] mode_r [2];
    logic [7:0] dir_r [4];
    logic [7:0] drive_r [4];
    logic [7:0] dout_r [4];
    logic [7:0] oe_stat_r [3];
    logic [7:0] mask_ab_r;
    logic [7:0] mask_bc_r;
    logic [7:0] en_nxt [4];
    logic [7:0] val_nxt [4];
    pcfg_pkg::pcfg_pad_type pad_nxt [4];
    logic [7:0] rd_nxt;
    logic [1:0] acc_port;
    logic [3:0] acc_reg;
    logic wr_hit;
    logic ab_load;
    logic bc_load;
    logic [7:0] ab_host;
    logic [7:0] bc_host;
    logic [7:0] view_nxt;
    logic [7:0] od_nxt [4];
    logic wr_mode;
    logic wr_mask;
    logic wr_dir;
    logic wr_drive;
    logic wr_dout;

    // Valid pins of a port
    function automatic logic [7:0] port_mask(input logic [1:0] p);
        port_mask = (p == 2'd3) ? `PCFG_D_USED : 8'hff;
    endfunction : port_mask

    function automatic logic ab_at(input logic [1:0] p);
        ab_at = (p == 2'd0 && !AB_ON_B) || (p == 2'd1 && AB_ON_B);
    endfunction : ab_at

    function automatic logic bc_at(input logic [1:0] p);
        bc_at = (p == 2'd1 && !BC_ON_C) || (p == 2'd2 && BC_ON_C);
    endfunction : bc_at

    // Output cells seen at a port
    function automatic logic [7:0] cell_view(input logic [1:0] p, input logic [7:0] ab,
                                             input logic [7:0] bc);
        cell_view = (ab_at(p) ? ab : 8'h00) | (bc_at(p) ? bc : 8'h00);
    endfunction : cell_view

    function automatic logic [7:0] open_drain(input logic [1:0] p, input logic [7:0] d);
        unique case (p)
            2'd0, 2'd1: open_drain = d & `PCFG_AB_OPEN_DRAIN;
            2'd2: open_drain = d & `PCFG_C_OPEN_DRAIN;
            default: open_drain = 8'h00;
        endcase
    endfunction : open_drain

    function automatic logic [7:0] fast_slew(input logic [1:0] p, input logic [7:0] d);
        unique case (p)
            2'd0, 2'd1: fast_slew = d & `PCFG_AB_SLEW;
            2'd3: fast_slew = d & `PCFG_D_SLEW;
            default: fast_slew = 8'h00;
        endcase
    endfunction : fast_slew

    assign acc_port = HOST.addr[5:4];
    assign acc_reg = HOST.addr[3:0];
    assign wr_hit = HOST.sel && HOST.wr && HOST.addr[7:6] == 2'b00;
    assign ab_load = wr_hit && acc_reg == `PCFG_REG_OUT_CELL && ab_at(acc_port);
    assign bc_load = wr_hit && acc_reg == `PCFG_REG_OUT_CELL && bc_at(acc_port);
    assign ab_host = ~mask_ab_r & {8{ab_load}};
    assign bc_host = ~mask_bc_r & {8{bc_load}};

    // Write strobes per register kind
    assign wr_mode = wr_hit && acc_reg == `PCFG_REG_MODE && !acc_port[1];
    assign wr_mask = wr_hit && acc_reg == `PCFG_REG_MASK;
    assign wr_dir = wr_hit && acc_reg == `PCFG_REG_DIR;
    assign wr_drive = wr_hit && acc_reg == `PCFG_REG_DRIVE;
    assign wr_dout = wr_hit && acc_reg == `PCFG_REG_DATA_OUT;

    // Mode select, ports A and B
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            mode_r[0] <= `PCFG_RESET_VAL;
            mode_r[1] <= `PCFG_RESET_VAL;
        end else if (wr_mode) begin
            mode_r[acc_port[0]] <= HOST.wdata;
        end
    end

    // Direction, drive select and output latch
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            for (int p = 0; p < 4; p++) begin
                dir_r[p] <= `PCFG_RESET_VAL;
                drive_r[p] <= `PCFG_RESET_VAL;
                dout_r[p] <= `PCFG_RESET_VAL;
            end
        end else begin
            // Read-only locations fall through untouched
            if (wr_dir) begin
                dir_r[acc_port] <= HOST.wdata & port_mask(acc_port);
            end
            if (wr_drive) begin
                drive_r[acc_port] <= HOST.wdata & port_mask(acc_port);
            end
            if (wr_dout) begin
                dout_r[acc_port] <= HOST.wdata & port_mask(acc_port);
            end
        end
    end

    // Output cell load masks
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            mask_ab_r <= `PCFG_RESET_VAL;
            mask_bc_r <= `PCFG_RESET_VAL;
        end else if (wr_mask) begin
            if (ab_at(acc_port)) begin
                mask_ab_r <= HOST.wdata;
            end
            if (bc_at(acc_port)) begin
                mask_bc_r <= HOST.wdata;
            end
        end
    end

    // Output cells: host load wins on unmasked bits
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            CELL_AB_Q <= `PCFG_RESET_VAL;
            CELL_BC_Q <= `PCFG_RESET_VAL;
        end else begin
            CELL_AB_Q <= (ab_host & HOST.wdata) | (~ab_host & (CELL_CE ? CELL_AB_D : CELL_AB_Q));
            CELL_BC_Q <= (bc_host & HOST.wdata) | (~bc_host & (CELL_CE ? CELL_BC_D : CELL_BC_Q));
        end
    end

    // Input cells follow pins while capture is high
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            IN_CELL_Q <= 24'h00_0000;
        end else begin
            for (int c = 0; c < 3; c++) begin
                if (IN_CELL_CAPTURE[c]) begin
                    IN_CELL_Q[c*8 +: 8] <= PIN_IN[c*8 +: 8];
                end
            end
        end
    end

    // Pin value and driver enable per port
    always_comb begin
        view_nxt = 8'h00;
        for (int p = 0; p < 4; p++) begin
            en_nxt[p] = dir_r[p];
            if (p < 3) begin
                en_nxt[p] = dir_r[p] | PLA_OE[p*8 +: 8];
            end
            en_nxt[p] = en_nxt[p] & port_mask(2'(p));
            val_nxt[p] = dout_r[p];
            view_nxt = cell_view(2'(p), CELL_AB_Q, CELL_BC_Q);
            for (int n = 0; n < 8; n++) begin
                if (CELL_PINS[p*8 + n]) begin
                    val_nxt[p][n] = view_nxt[n];
                end else if (p < 2 && mode_r[p[0]][n]) begin
                    val_nxt[p][n] = LATCHED_ADDR[n];
                end
            end
        end
        if (MEM_MODE[`PCFG_PERIPH_BIT]) begin
            en_nxt[0] = {8{(PERIPH_SEL_0 || PERIPH_SEL_1) && HOST_DATA_WR}};
            val_nxt[0] = HOST_DATA;
        end
        for (int p = 0; p < 4; p++) begin
            od_nxt[p] = open_drain(2'(p), drive_r[p]);
            // Open drain only pulls low, a one releases the pin
            pad_nxt[p].dout = val_nxt[p] & ~od_nxt[p];
            pad_nxt[p].oe = en_nxt[p] & ~(od_nxt[p] & val_nxt[p]);
            pad_nxt[p].fast = fast_slew(2'(p), drive_r[p]);
        end
    end

    // Pads and driver status
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            PAD_A <= '0;
            PAD_B <= '0;
            PAD_C <= '0;
            PAD_D <= '0;
            for (int p = 0; p < 3; p++) begin
                oe_stat_r[p] <= `PCFG_RESET_VAL;
            end
        end else begin
            PAD_A <= pad_nxt[0];
            PAD_B <= pad_nxt[1];
            PAD_C <= pad_nxt[2];
            PAD_D <= pad_nxt[3];
            for (int p = 0; p < 3; p++) begin
                oe_stat_r[p] <= en_nxt[p];
            end
        end
    end

    // Read data selection
    always_comb begin
        rd_nxt = 8'h00;
        unique case (acc_reg)
            `PCFG_REG_DATA_IN: begin
                rd_nxt = PIN_IN[acc_port*8 +: 8];
            end
            `PCFG_REG_MODE: begin
                // No mode register on ports C and D
                if (!acc_port[1]) begin
                    rd_nxt = mode_r[acc_port[0]];
                end
            end
            `PCFG_REG_DATA_OUT: begin
                rd_nxt = dout_r[acc_port];
            end
            `PCFG_REG_DIR: begin
                rd_nxt = dir_r[acc_port];
            end
            `PCFG_REG_DRIVE: begin
                rd_nxt = drive_r[acc_port];
            end
            `PCFG_REG_OUT_CELL: begin
                rd_nxt = cell_view(acc_port, CELL_AB_Q, CELL_BC_Q);
            end
            `PCFG_REG_MASK: begin
                if (ab_at(acc_port)) begin
                    rd_nxt = rd_nxt | mask_ab_r;
                end
                if (bc_at(acc_port)) begin
                    rd_nxt = rd_nxt | mask_bc_r;
                end
            end
            `PCFG_REG_IN_CELL: begin
                if (acc_port != 2'd3) begin
                    rd_nxt = IN_CELL_Q[acc_port*8 +: 8];
                end
            end
            `PCFG_REG_OE_STAT: begin
                if (acc_port != 2'd3) begin
                    rd_nxt = oe_stat_r[acc_port];
                end
            end
            default: begin
                rd_nxt = 8'h00;
            end
        endcase
        rd_nxt = rd_nxt & port_mask(acc_port);
        if (HOST.addr[7:6] != 2'b00) begin
            rd_nxt = 8'h00;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else if (HOST.sel && HOST.rd) begin
            RDATA <= rd_nxt;
        end else begin
            RDATA <= 8'h00;
        end
    end

    // Port A levels toward the host in peripheral mode
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            PERIPH_RDATA <= 8'h00;
        end else begin
            PERIPH_RDATA <= PIN_IN[7:0];
        end
    end

endmodule : pcfg_port_regs

//--- pcfg_port_regs_checker.sv
// Purpose: Port timing and mapping checks
// Assumes: One clock, sync reset
// Notes: Bound to pcfg_port_regs
`timescale 1ns/1ps
module pcfg_port_regs_checker (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire pcfg_pkg::pcfg_bus_type HOST,
    input wire logic [7:0] RDATA,
    input wire logic [31:0] PIN_IN,
    input wire pcfg_pkg::pcfg_pad_type PAD_A,
    input wire pcfg_pkg::pcfg_pad_type PAD_D,
    input wire logic [23:0] PLA_OE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    logic rd;
    logic wr;
    assign rd = HOST.sel && HOST.rd;
    assign wr = HOST.sel && HOST.wr;
    AST_RESET_CLEAR: assert property ($fell(RESET) |-> PAD_A.oe == 8'h00 && RDATA == 8'h00)
        else $error("outputs not clear after reset");
    AST_RDATA_IDLE: assert property (!rd |=> RDATA == 8'h00)
        else $error("read data without read");
    AST_DATA_IN: assert property (rd && HOST.addr == 8'h00 |=> RDATA == $past(PIN_IN[7:0]))
        else $error("input data not live pins");
    AST_D_UNUSED: assert property (rd && HOST.addr == 8'h33 |=> (RDATA & 8'hf9) == 8'h00)
        else $error("unused bits read nonzero");
    AST_OE_STATUS: assert property (rd && HOST.addr == 8'h06 && PLA_OE[7:0] == 8'hff
        && $past(PLA_OE[7:0]) == 8'hff |=> RDATA == 8'hff)
        else $error("status ignores logic enable");
    AST_D_DIR: assert property (wr && HOST.addr == 8'h33
        |=> ##1 PAD_D.oe == ($past(HOST.wdata, 2) & 8'h06))
        else $error("port D enable wrong");
    AST_D_SLEW: assert property (wr && HOST.addr == 8'h34
        |=> ##1 PAD_D.fast == ($past(HOST.wdata, 2) & 8'h06))
        else $error("port D slew wrong");
    AST_A_SLEW: assert property (wr && HOST.addr == 8'h04
        |=> ##1 PAD_A.fast == ($past(HOST.wdata, 2) & 8'h0f))
        else $error("port A slew wrong");
endmodule : pcfg_port_regs_checker

bind pcfg_port_regs pcfg_port_regs_checker u_pcfg_port_regs_checker (
    .CLOCK(CLOCK), .RESET(RESET), .HOST(HOST), .RDATA(RDATA), .PIN_IN(PIN_IN),
    .PAD_A(PAD_A), .PAD_D(PAD_D), .PLA_OE(PLA_OE)
);

//--- pcfg_pin_model.sv
// Purpose: External circuitry on the port pins
// Assumes: Undriven pins follow the outside level
// Notes: Open drain pins wire-and with the outside
`timescale 1ns/1ps
module pcfg_pin_model (
    input wire pcfg_pkg::pcfg_pad_type pad_a,
    input wire pcfg_pkg::pcfg_pad_type pad_b,
    input wire pcfg_pkg::pcfg_pad_type pad_c,
    input wire pcfg_pkg::pcfg_pad_type pad_d,
    input wire logic [31:0] ext,
    output logic [31:0] pin
);
    assign pin[7:0] = (pad_a.oe & pad_a.dout) | (~pad_a.oe & ext[7:0]);
    assign pin[15:8] = (pad_b.oe & pad_b.dout) | (~pad_b.oe & ext[15:8]);
    assign pin[23:16] = (pad_c.oe & pad_c.dout) | (~pad_c.oe & ext[23:16]);
    assign pin[31:24] = (pad_d.oe & pad_d.dout) | (~pad_d.oe & ext[31:24]);
endmodule : pcfg_pin_model

//--- pcfg_port_regs_bench.sv
// Purpose: Self-checking bench for pcfg_port_regs
// Assumes: Default parameters
// Notes: Reads queue expectations for the monitor
`timescale 1ns/1ps
module pcfg_port_regs_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    pcfg_pkg::pcfg_bus_type host = '0;
    pcfg_pkg::pcfg_pad_type pad_a, pad_b, pad_c, pad_d;
    logic [7:0] rdata;
    logic [31:0] pin_in;
    logic [31:0] ext = 32'h0;
    logic [23:0] pla_oe = 24'h0;
    logic [2:0] capture = 3'h0;
    logic [7:0] laddr = 8'h00;
    logic [7:0] mem_mode = 8'h00;
    logic psel = 1'b0;
    logic [7:0] hdata = 8'h00;
    logic hdata_wr = 1'b0;
    logic [7:0] exp_q[$];
    logic pend = 1'b0;
    logic [7:0] v;
    logic [7:0] d;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #10 clock = ~clock;
    pcfg_port_regs u_pcfg_port_regs (
        .CLOCK(clock), .RESET(reset), .HOST(host), .RDATA(rdata), .PIN_IN(pin_in),
        .PAD_A(pad_a), .PAD_B(pad_b), .PAD_C(pad_c), .PAD_D(pad_d), .PLA_OE(pla_oe),
        .CELL_AB_D(8'h00), .CELL_BC_D(8'h00), .CELL_CE(1'b0), .CELL_AB_Q(),
        .CELL_BC_Q(), .IN_CELL_CAPTURE(capture), .IN_CELL_Q(), .LATCHED_ADDR(laddr),
        .MEM_MODE(mem_mode), .PERIPH_SEL_0(psel), .PERIPH_SEL_1(1'b0),
        .HOST_DATA(hdata), .HOST_DATA_WR(hdata_wr), .PERIPH_RDATA()
    );
    pcfg_pin_model u_pcfg_pin_model (
        .pad_a(pad_a), .pad_b(pad_b), .pad_c(pad_c), .pad_d(pad_d), .ext(ext), .pin(pin_in)
    );
    task automatic test_done();
        $display("checked %0d failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch rdata expected %h seen %h", exp, seen);
        end
    endtask : check
    // Read when r is set, w then holds the expected data
    task automatic rw(input bit r, input logic [7:0] a, input logic [7:0] w);
        host = '{1'b1, !r, r, a, w};
        if (r) exp_q.push_back(w);
        @(posedge clock);
        #1;
    endtask : rw
    task automatic settle();
        host = '0;
        repeat (3) @(posedge clock);
        #1;
    endtask : settle
    task automatic tdone(input string s);
        settle();
        $display("test %s done", s);
    endtask : tdone
    always @(posedge clock) begin
        if (pend) check(rdata, exp_q.pop_front());
        pend = host.sel && host.rd && !reset;
        cycles++;
        if (cycles == 2000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h50e9));
        ext = $urandom;
        repeat (6) @(posedge clock);
        #1;
        reset = 1'b0;
        for (int p = 0; p < 4; p++) begin
            rw(1, {2'b00, p[1:0], 4'h1}, 8'h00);
            rw(1, {2'b00, p[1:0], 4'h3}, 8'h00);
            rw(1, {2'b00, p[1:0], 4'h4}, 8'h00);
        end
        tdone("reset");
        d = 8'($urandom);
        rw(0, 8'h13, d);
        rw(0, 8'h03, d);
        rw(0, 8'h33, 8'hff);
        rw(0, 8'h34, 8'hff);
        rw(0, 8'h04, d);
        rw(1, 8'h13, d);
        rw(1, 8'h33, 8'h06);
        rw(1, 8'h34, 8'h06);
        rw(1, 8'h04, d);
        rw(0, 8'h06, ~d);
        rw(0, 8'h05, 8'hff);
        rw(0, 8'h00, 8'hff);
        rw(1, 8'h06, d);
        rw(1, 8'h05, 8'h00);
        rw(1, 8'h00, ext[7:0] & ~d);
        tdone("config");
        v = 8'($urandom);
        rw(0, 8'h02, v);
        rw(0, 8'h04, 8'h00);
        pla_oe[7:0] = 8'hff;
        settle();
        rw(1, 8'h06, 8'hff);
        rw(1, 8'h00, v);
        rw(1, 8'h02, v);
        pla_oe[7:0] = 8'h00;
        settle();
        rw(1, 8'h06, d);
        rw(1, 8'h00, (v & d) | (ext[7:0] & ~d));
        tdone("data");
        laddr = 8'($urandom);
        rw(0, 8'h11, 8'hff);
        rw(0, 8'h13, 8'hff);
        settle();
        rw(1, 8'h10, laddr);
        rw(0, 8'h11, 8'h00);
        settle();
        rw(1, 8'h10, 8'h00);
        rw(0, 8'h07, v);
        rw(1, 8'h07, v);
        rw(0, 8'h08, 8'hff);
        rw(0, 8'h07, ~v);
        rw(1, 8'h07, v);
        rw(1, 8'h08, 8'hff);
        tdone("cells");
        ext[23:16] = 8'($urandom);
        rw(0, 8'h24, 8'hff);
        rw(0, 8'h23, 8'hff);
        rw(0, 8'h22, v);
        capture = 3'h1;
        settle();
        rw(1, 8'h20, v & ext[23:16]);
        rw(1, 8'h05, (v & d) | (ext[7:0] & ~d));
        tdone("drive");
        rw(0, 8'h03, 8'h00);
        rw(0, 8'h13, 8'h00);
        mem_mode = 8'h80;
        hdata = ~ext[7:0];
        hdata_wr = 1'b1;
        settle();
        rw(1, 8'h00, ext[7:0]);
        rw(1, 8'h10, ext[15:8]);
        psel = 1'b1;
        settle();
        rw(1, 8'h00, ~ext[7:0]);
        tdone("peripheral");
        test_done();
    end
endmodule : pcfg_port_regs_bench
